// [cvd_diag.sv]
// Coil-voltage averaging, stall detection and fault flag logic with Avalon-MM registers
`timescale 1ns/100ps
module cvd_diag #(
	parameter int V5_START = cvd_pkg::V5_START_CYC      // Regulator start-up timeout
) (
	input  wire logic                      i_clk_sys,          // 20 MHz clock
	input  wire logic                      i_srst,             // Sync reset, high
	input  wire logic [5:0]                i_avs_address,      // Byte address
	input  wire logic                      i_avs_read,         // Read request
	input  wire logic                      i_avs_write,        // Write request
	input  wire logic [31:0]               i_avs_writedata,    // Write data
	output logic      [31:0]               o_avs_readdata,     // Read data
	output logic                           o_avs_waitrequest,  // Stall strobe
	input  wire logic                      i_pwm_start,        // PWM period start pulse
	input  wire logic                      i_adc_valid,        // Conversion done pulse
	input  wire logic [cvd_pkg::CV_W-1:0]  i_adc_data,         // Coil voltage sample
	input  wire logic                      i_zc_start,         // Zero-current step begins
	input  wire logic                      i_step_cmd,         // Step update request
	input  wire logic [1:0]                i_result_sel,       // Result slot for this step
	input  wire logic                      i_sup_over,         // Supply above over threshold
	input  wire logic                      i_sup_under,        // Supply below under threshold
	input  wire logic                      i_reg_over,         // Regulator input over
	input  wire logic                      i_reg_under,        // Regulator input under
	input  wire logic                      i_reg_por,          // Regulator input below POR
	input  wire logic                      i_vdd_por,          // I/O supply below POR
	input  wire logic                      i_pump_low,         // Pump voltage too low
	input  wire logic                      i_v5_low,           // 5 V below warning level
	input  wire logic                      i_v5_over,          // 5 V above over level
	input  wire logic                      i_v5_below_fail,    // 5 V below fail level
	input  wire logic                      i_temp_warn,        // Warning temperature
	input  wire logic                      i_temp_shut,        // Shutdown temperature
	input  wire logic                      i_overcurrent,      // Any switch over limit
	input  wire logic                      i_cur_reached_a,    // Phase A at reference
	input  wire logic                      i_cur_reached_b,    // Phase B at reference
	output logic                           o_step_apply,       // Phase counter update pulse
	output logic                           o_motor_output_enable, // Bridges enabled
	output logic                           o_pump_enable,      // Charge pump on
	output logic                           o_reg_enable,       // 5 V regulator on
	output logic                           o_hold_request_bit, // Hold mode request
	output logic                           o_conversion_ready_out, // Result available
	output logic                           o_runaway_out,      // Outside upper / lower A
	output logic                           o_below_lower_b_out, // Below lower B
	output logic                           o_fault_summary,    // Any status flag
	output logic                           o_flag_set_pulse_out, // Flag newly set
	output logic                           o_por_active        // Internal POR in force
);
	import cvd_pkg::*;

	typedef struct packed {
		logic [P_W-1:0]       sync1;
		logic [P_W-1:0]       sync2;
		logic                 ack;
		logic [31:0]          rdata;
		logic [G_W-1:0]       global_status_reg;
		logic                 above_upper_flag;
		logic                 below_lower_a_flag;
		logic                 below_lower_b_flag;
		logic [1:0]           open_load;
		logic                 me;
		logic                 hold;
		logic [4:0]           delay;
		logic [2:0]           stall_count_limit;
		logic                 auto_hold_on_stall;
		logic                 cv_en;
		logic [1:0]           last_result_index;
		logic [CV_W-1:0]      upper_voltage_limit;
		logic [CV_W-1:0]      lower_voltage_limit_a;
		logic [CV_W-1:0]      lower_voltage_limit_b;
		logic [1:0]           freq;
		logic                 open_load_delay_sel;
		logic [3:0][CV_W-1:0] coil_voltage_result;
		logic [13:0]          acc;
		logic [4:0]           scnt;
		logic [CV_W-1:0]      avg;
		logic                 zc;
		logic                 stored;
		logic                 pend;
		logic [4:0]           pcnt;
		logic                 rdy;
		logic                 run;
		logic                 llo;
		logic [2:0]           stall_cnt;
		logic                 ec;
		logic                 step;
		logic [7:0]           oc_cnt;
		logic [1:0][11:0]     ol_cnt;
		logic [1:0]           ol_done;
		logic                 v5_up;
		logic [16:0]          v5_tmr;
	} cvd_state_t;

	localparam cvd_state_t RST = '0;

	cvd_state_t s_reg;
	cvd_state_t s_next;
	cvd_state_t n;
	logic [P_W-1:0] pins;
	logic           trig;
	logic           out_rng;
	logic           por;
	logic [G_W-1:0] gset;
	logic [G_W-1:0] gclr;
	logic [3:0]     widx;
	logic           acc_w;

	// Word index of a bus address, used by both read and write decode
	function automatic logic [3:0] word_of(input logic [5:0] a);
		return a[5:2];
	endfunction

	assign pins = {i_cur_reached_b, i_cur_reached_a, i_overcurrent, i_temp_shut, i_temp_warn,
		i_v5_below_fail, i_v5_over, i_v5_low, i_pump_low, i_vdd_por, i_reg_por,
		i_reg_under, i_reg_over, i_sup_under, i_sup_over};
	assign widx  = word_of(i_avs_address);
	assign acc_w = i_avs_write & s_reg.ack;

	// Next-state logic for the whole block
	always_comb begin
		n = s_reg;
		trig = 1'b0;
		out_rng = 1'b0;
		gset = '0;
		gclr = '0;
		// Two-stage synchronisers; stage one feeds stage two only
		n.sync1 = pins;
		n.sync2 = s_reg.sync1;
		por = s_reg.sync2[P_REG_POR] | s_reg.sync2[P_VDD_POR];
		// Bus: one wait cycle, read data registered during it
		n.ack = (i_avs_read | i_avs_write) & ~s_reg.ack;
		n.rdata = '0;
		unique case (widx)
			A_GLOBAL_STATUS: n.rdata[G_W-1:0] = s_reg.global_status_reg;
			A_MOTOR_STATUS:  n.rdata[4:0] = {s_reg.open_load, s_reg.below_lower_b_flag,
				s_reg.below_lower_a_flag, s_reg.above_upper_flag};
			A_MOTOR_CTRL1:   n.rdata[1:0] = {s_reg.hold, s_reg.me};
			A_MOTOR_CTRL3:   n.rdata[12:0] = {s_reg.last_result_index, 1'b0, s_reg.cv_en,
				s_reg.auto_hold_on_stall, s_reg.stall_count_limit, s_reg.delay};
			A_UPPER_LIMIT:   n.rdata[CV_W-1:0] = s_reg.upper_voltage_limit;
			A_LOWER_A:       n.rdata[CV_W-1:0] = s_reg.lower_voltage_limit_a;
			A_LOWER_B:       n.rdata[CV_W-1:0] = s_reg.lower_voltage_limit_b;
			A_MOTOR_CTRL2:   n.rdata[2:0] = {s_reg.open_load_delay_sel, s_reg.freq};
			default: begin
				if (widx >= A_RESULT0 && widx <= A_RESULT0 + 4'h3) begin
					n.rdata[CV_W-1:0] = s_reg.coil_voltage_result[2'(widx - A_RESULT0)];
				end
			end
		endcase
		// Control register writes
		if (acc_w) begin
			unique case (widx)
				A_GLOBAL_STATUS: gclr = i_avs_writedata[G_W-1:0];
				A_MOTOR_CTRL1: begin
					n.hold = i_avs_writedata[1];
					// Enable refused while a blocking fault is latched
					n.me = i_avs_writedata[0] & ~|(s_reg.global_status_reg & ME_BLOCK);
				end
				A_MOTOR_CTRL3: begin
					n.delay = i_avs_writedata[4:0];
					n.stall_count_limit = i_avs_writedata[7:5];
					n.auto_hold_on_stall = i_avs_writedata[8];
					n.cv_en = i_avs_writedata[9];
				end
				A_UPPER_LIMIT: n.upper_voltage_limit = i_avs_writedata[CV_W-1:0];
				A_LOWER_A:     n.lower_voltage_limit_a = i_avs_writedata[CV_W-1:0];
				A_LOWER_B:     n.lower_voltage_limit_b = i_avs_writedata[CV_W-1:0];
				A_MOTOR_CTRL2: {n.open_load_delay_sel, n.freq} = i_avs_writedata[2:0];
				default: ;
			endcase
		end
		// Averaging over one PWM period; fast rates use fewer samples
		if (i_adc_valid && s_reg.scnt < (s_reg.freq[1] ? SAMP_LO : SAMP_HI)) begin
			n.acc = s_reg.acc + 14'(i_adc_data);
			n.scnt = s_reg.scnt + 5'h01;
		end
		if (i_pwm_start) begin
			if (s_reg.freq[1] && s_reg.scnt == SAMP_LO) begin
				n.avg = CV_W'(s_reg.acc >> SHIFT_LO);
			end else if (!s_reg.freq[1] && s_reg.scnt == SAMP_HI) begin
				n.avg = CV_W'(s_reg.acc >> SHIFT_HI);
			end
			n.acc = '0;
			n.scnt = '0;
		end
		// Zero-current step tracking and trigger generation
		n.step = 1'b0;
		if (s_reg.zc && !s_reg.stored && s_reg.delay != 5'h00 && i_pwm_start) begin
			n.pcnt = s_reg.pcnt + 5'h01;
			if (s_reg.pcnt + 5'h01 == s_reg.delay) begin
				trig = 1'b1;
			end
		end
		if (i_step_cmd || s_reg.pend) begin
			if (!s_reg.zc) begin
				n.step = 1'b1;
				n.pend = 1'b0;
			end else if (s_reg.delay == 5'h00) begin
				trig = 1'b1;
				n.step = 1'b1;
				n.zc = 1'b0;
				n.pend = 1'b0;
			end else if (s_reg.stored || trig) begin
				n.step = 1'b1;
				n.zc = 1'b0;
				n.pend = 1'b0;
			end else begin
				n.pend = 1'b1;
			end
		end
		if (i_zc_start && s_reg.cv_en) begin
			n.zc = 1'b1;
			n.stored = 1'b0;
			n.pcnt = '0;
			n.rdy = 1'b0;
		end
		// Store, compare and count on each trigger; a period closing now is stored fresh
		if (trig) begin
			n.stored = 1'b1;
			n.coil_voltage_result[i_result_sel] = n.avg;
			n.last_result_index = i_result_sel;
			n.rdy = 1'b1;
			n.above_upper_flag = n.avg > s_reg.upper_voltage_limit;
			n.below_lower_a_flag = n.avg < s_reg.lower_voltage_limit_a;
			n.below_lower_b_flag = n.avg < s_reg.lower_voltage_limit_b;
			out_rng = n.above_upper_flag | n.below_lower_a_flag;
			n.run = out_rng;
			n.llo = n.below_lower_b_flag;
			if (!out_rng) begin
				n.stall_cnt = '0;
			end else if (s_reg.stall_cnt != 3'h7) begin
				n.stall_cnt = s_reg.stall_cnt + 3'h1;
			end
			// A limit of zero leaves stall detection off
			if (out_rng && s_reg.stall_count_limit != 3'h0
				&& {1'b0, s_reg.stall_cnt} + 4'h1 >= {1'b0, s_reg.stall_count_limit}) begin
				gset[G_STALL] = 1'b1;
			end
		end
		// Overcurrent filter: must persist past the filter time
		n.oc_cnt = s_reg.sync2[P_OC] ? ((s_reg.oc_cnt == OC_LIMIT) ? OC_LIMIT
			: s_reg.oc_cnt + 8'h01) : 8'h00;
		gset[G_OC] = s_reg.oc_cnt == OC_LIMIT;
		// Open load: timer per phase from each PWM start
		for (int p = 0; p < 2; p++) begin
			if (i_pwm_start) begin
				n.ol_cnt[p] = '0;
				n.ol_done[p] = 1'b0;
			end else if (!s_reg.ol_done[p]) begin
				if (s_reg.sync2[P_CUR_A + p]) begin
					n.ol_done[p] = 1'b1;
				end else if (s_reg.ol_cnt[p] == (s_reg.open_load_delay_sel ? OL_LONG_CYC
					: OL_SHORT_CYC)) begin
					n.ol_done[p] = 1'b1;
					n.open_load[p] = 1'b1;
				end else begin
					n.ol_cnt[p] = s_reg.ol_cnt[p] + 12'h001;
				end
			end
		end
		// Only a newly failing phase sets the summary, so a host clear can take
		gset[G_OL] = |(n.open_load & ~s_reg.open_load);
		// Regulator start-up watch: a drop below fail after rising is a short
		if (!s_reg.sync2[P_V5_FAIL]) begin
			n.v5_up = 1'b1;
		end else if (!s_reg.v5_up && o_reg_enable && s_reg.v5_tmr != 17'(V5_START)) begin
			n.v5_tmr = s_reg.v5_tmr + 17'h00001;
		end
		// Short and timeout count only while the regulator runs, so a clear restarts it
		gset[G_V5F] = s_reg.sync2[P_V5_OV]
			| (s_reg.v5_up & s_reg.sync2[P_V5_FAIL] & o_reg_enable)
			| (n.v5_tmr == 17'(V5_START) && s_reg.v5_tmr != 17'(V5_START));
		// Level-driven flags; set beats clear, so a live cause cannot be cleared
		gset[G_SUP_OV] = s_reg.sync2[P_SUP_OV];
		gset[G_SUP_UV] = s_reg.sync2[P_SUP_UV];
		gset[G_REG_OV] = s_reg.sync2[P_REG_OV];
		gset[G_REG_UV] = s_reg.sync2[P_REG_UV];
		gset[G_CP]     = s_reg.sync2[P_CP_LOW];
		gset[G_V5W]    = s_reg.sync2[P_V5_LOW];
		gset[G_TW]     = s_reg.sync2[P_TW];
		gset[G_TSD]    = s_reg.sync2[P_TSD];
		n.global_status_reg = (s_reg.global_status_reg & ~gclr) | gset;
		if (gclr[G_OL]) begin
			n.open_load = n.open_load & ~s_reg.open_load;
		end
		if (gclr[G_V5F] && !gset[G_V5F]) begin
			n.v5_up = 1'b0;
			n.v5_tmr = '0;
		end
		// Blocking faults drop the motor enable
		if (|(gset & ME_BLOCK)) begin
			n.me = 1'b0;
		end
		if (gset[G_STALL] && s_reg.auto_hold_on_stall) begin
			n.hold = 1'b1;
		end
		// Change indicator: a new set wins over the clearing read
		if (i_avs_read && s_reg.ack && widx == A_GLOBAL_STATUS) begin
			n.ec = 1'b0;
		end
		if (|(gset & ~s_reg.global_status_reg)) begin
			n.ec = 1'b1;
		end
		// Power-on reset from either supply; synchronisers keep running
		if (por) begin
			n = RST;
			n.sync1 = pins;
			n.sync2 = s_reg.sync1;
		end
	end

	// State register
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			s_reg <= RST;
		end else begin
			s_reg <= s_next;
		end
	end
	assign s_next = n;

	// Outputs
	assign o_avs_readdata         = s_reg.rdata;
	assign o_avs_waitrequest      = (i_avs_read | i_avs_write) & ~s_reg.ack;
	assign o_step_apply           = s_reg.step;
	assign o_motor_output_enable  = s_reg.me & ~s_reg.global_status_reg[G_TSD];
	assign o_pump_enable          = ~|(s_reg.global_status_reg & ME_BLOCK & ~(12'h1 << G_OC));
	assign o_reg_enable           = ~(s_reg.global_status_reg[G_REG_OV] | s_reg.global_status_reg[G_V5F]
		| s_reg.global_status_reg[G_TSD]);
	assign o_hold_request_bit     = s_reg.hold;
	assign o_conversion_ready_out = s_reg.rdy;
	assign o_runaway_out          = s_reg.run;
	assign o_below_lower_b_out    = s_reg.llo;
	assign o_fault_summary        = |s_reg.global_status_reg;
	assign o_flag_set_pulse_out   = s_reg.ec;
	assign o_por_active           = s_reg.sync2[P_REG_POR] | s_reg.sync2[P_VDD_POR];

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	chk_ready_on_trig: assert property (trig && !por |=> o_conversion_ready_out)
		else $error("ready did not rise on trigger");
	chk_runaway_value: assert property (trig && !por |=> o_runaway_out ==
		(s_reg.avg > $past(s_reg.upper_voltage_limit)
		|| s_reg.avg < $past(s_reg.lower_voltage_limit_a)))
		else $error("runaway output wrong");
	chk_lower_b_value: assert property (trig && !por |=> o_below_lower_b_out ==
		(s_reg.avg < $past(s_reg.lower_voltage_limit_b)))
		else $error("lower B output wrong");
	chk_stall_in_range: assert property (trig && !por && !out_rng |=>
		s_reg.stall_cnt == 3'h0)
		else $error("stall counter not cleared");
	chk_auto_hold_set: assert property (
		gset[G_STALL] && s_reg.auto_hold_on_stall && !por
		|=> o_hold_request_bit && s_reg.global_status_reg[G_STALL])
		else $error("auto hold not taken");
	chk_enable_drops: assert property (|(gset & ME_BLOCK) && !por
		|=> !o_motor_output_enable && (!o_pump_enable || s_reg.global_status_reg[G_OC]))
		else $error("enable not dropped on fault");
	chk_fault_or_all: assert property (|gset && !por |=> o_fault_summary)
		else $error("fault summary mismatch");
	chk_change_set: assert property (|(gset & ~s_reg.global_status_reg) && !por
		|=> o_flag_set_pulse_out)
		else $error("change output missed a set");
	chk_early_step_held: assert property (
		i_step_cmd && s_reg.zc && s_reg.delay != 5'h00 && !s_reg.stored && !trig
		&& !por && !i_zc_start |=> !o_step_apply)
		else $error("step applied before delay");
endmodule

// [cvd_diag_bench.sv]
// Self-checking bench of the coil-voltage diagnostic block
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module cvd_diag_bench;
	import cvd_pkg::*;
	logic i_clk_sys, i_srst, i_pwm_start, i_adc_valid, i_zc_start, i_step_cmd;
	logic i_avs_read, i_avs_write, o_avs_waitrequest;
	logic [5:0] i_avs_address, h_addr;
	logic [31:0] i_avs_writedata, o_avs_readdata, rd, h_wd, h_rd;
	logic [CV_W-1:0] i_adc_data;
	logic [1:0] i_result_sel;
	logic i_sup_over, i_sup_under, i_reg_over, i_reg_under, i_reg_por, i_vdd_por, i_pump_low;
	logic i_v5_low, i_v5_over, i_v5_below_fail, i_temp_warn, i_temp_shut, i_overcurrent;
	logic i_cur_reached_a, i_cur_reached_b, o_step_apply, o_motor_output_enable, o_pump_enable;
	logic o_reg_enable, o_hold_request_bit, o_conversion_ready_out, o_runaway_out;
	logic o_below_lower_b_out, o_fault_summary, o_flag_set_pulse_out, o_por_active;
	logic h_go, h_wr, h_done, saw_apply;
	int mismatches, check_count, cycles;
	cvd_diag #(.V5_START(50)) dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_pwm_start(i_pwm_start),
		.i_adc_valid(i_adc_valid), .i_adc_data(i_adc_data), .i_zc_start(i_zc_start),
		.i_step_cmd(i_step_cmd), .i_result_sel(i_result_sel), .i_sup_over(i_sup_over),
		.i_sup_under(i_sup_under), .i_reg_over(i_reg_over), .i_reg_under(i_reg_under),
		.i_reg_por(i_reg_por), .i_vdd_por(i_vdd_por), .i_pump_low(i_pump_low),
		.i_v5_low(i_v5_low), .i_v5_over(i_v5_over), .i_v5_below_fail(i_v5_below_fail),
		.i_temp_warn(i_temp_warn), .i_temp_shut(i_temp_shut),
		.i_overcurrent(i_overcurrent), .i_cur_reached_a(i_cur_reached_a),
		.i_cur_reached_b(i_cur_reached_b), .o_step_apply(o_step_apply),
		.o_motor_output_enable(o_motor_output_enable), .o_pump_enable(o_pump_enable),
		.o_reg_enable(o_reg_enable), .o_hold_request_bit(o_hold_request_bit),
		.o_conversion_ready_out(o_conversion_ready_out), .o_runaway_out(o_runaway_out),
		.o_below_lower_b_out(o_below_lower_b_out), .o_fault_summary(o_fault_summary),
		.o_flag_set_pulse_out(o_flag_set_pulse_out), .o_por_active(o_por_active));
	cvd_host host (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_go(h_go), .i_wr(h_wr),
		.i_addr(h_addr), .i_wdata(h_wd), .i_avs_waitrequest(o_avs_waitrequest),
		.i_avs_readdata(o_avs_readdata), .o_avs_read(i_avs_read), .o_avs_write(i_avs_write),
		.o_avs_address(i_avs_address), .o_avs_writedata(i_avs_writedata), .o_done(h_done),
		.o_rdata(h_rd));
	// 20 MHz clock
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	// Hang guard and step-apply watcher
	always @(posedge i_clk_sys) begin
		cycles <= cycles + 1;
		if (o_step_apply === 1'b1) saw_apply <= 1'b1;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// One bus cycle through the host model; waits for its completion strobe
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		h_wr <= w; h_addr <= a; h_wd <= d; h_go <= 1'b1;
		@(posedge i_clk_sys);
		h_go <= 1'b0;
		while (h_done !== 1'b1) @(negedge i_clk_sys);
		rd = h_rd;
	endtask
	// One PWM period of sixteen equal samples, closed by the next period start
	task automatic window(input logic [9:0] v);
		i_pwm_start <= 1'b1;
		@(posedge i_clk_sys);
		i_pwm_start <= 1'b0;
		repeat (16) begin
			i_adc_valid <= 1'b1; i_adc_data <= v;
			@(posedge i_clk_sys);
		end
		i_adc_valid <= 1'b0; i_pwm_start <= 1'b1;
		@(posedge i_clk_sys);
		i_pwm_start <= 1'b0;
	endtask
	// Zero-current step with immediate trigger; returns in the cycle after step command
	task automatic step(input logic [1:0] s, input logic [9:0] v);
		@(posedge i_clk_sys);
		i_zc_start <= 1'b1;
		@(posedge i_clk_sys);
		i_zc_start <= 1'b0;
		@(negedge i_clk_sys);
		`CHK(o_conversion_ready_out, 1'b0)
		@(posedge i_clk_sys);
		window(v);
		i_result_sel <= s; i_step_cmd <= 1'b1;
		@(posedge i_clk_sys);
		i_step_cmd <= 1'b0;
		@(negedge i_clk_sys);
	endtask
	task automatic t_por();
		`CHK({o_pump_enable, o_reg_enable, o_motor_output_enable}, 3'h6)
		bus(1'b1, 6'h08, 32'h1);
		bus(1'b1, 6'h3C, 32'hFFFF);
		bus(1'b0, 6'h3C, 32'h0); `CHK(rd, 32'h0)
		@(posedge i_clk_sys);
		i_vdd_por <= 1'b1;
		repeat (4) @(negedge i_clk_sys);
		`CHK({o_por_active, o_motor_output_enable}, 2'h2)
		@(posedge i_clk_sys);
		i_vdd_por <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		bus(1'b0, 6'h08, 32'h0); `CHK(rd, 32'h0)
	endtask
	// Two out-of-range steps against a stall limit of two, auto hold on
	task automatic t_stall();
		bus(1'b1, 6'h10, 32'h258);
		bus(1'b1, 6'h14, 32'hC8);
		bus(1'b1, 6'h18, 32'h96);
		bus(1'b1, 6'h1C, 32'h0);
		bus(1'b1, 6'h0C, 32'h340);
		step(2'h2, 10'h2BC);
		`CHK({o_conversion_ready_out, o_step_apply, o_runaway_out, o_below_lower_b_out}, 4'hE)
		bus(1'b0, 6'h28, 32'h0);
		`CHK(rd, 32'h2BC)
		bus(1'b0, 6'h0C, 32'h0); `CHK(rd[12:11], 2'h2)
		bus(1'b0, 6'h04, 32'h0); `CHK(rd[2:0], 3'h1)
		bus(1'b0, 6'h00, 32'h0); `CHK(rd[G_STALL], 1'b0)
		step(2'h3, 10'h64);
		`CHK({o_runaway_out, o_below_lower_b_out}, 2'h3)
		`CHK({o_fault_summary, o_flag_set_pulse_out}, 2'h3)
		bus(1'b0, 6'h00, 32'h0); `CHK(rd[G_STALL], 1'b1)
		@(negedge i_clk_sys);
		`CHK({o_flag_set_pulse_out, o_hold_request_bit}, 2'h1)
		bus(1'b0, 6'h08, 32'h0); `CHK(rd[1], 1'b1)
		bus(1'b0, 6'h04, 32'h0); `CHK(rd[2:0], 3'h6)
	endtask
	// Early step command under a two-period delay waits for the trigger; 8-sample rate
	task automatic t_delay();
		bus(1'b1, 6'h1C, 32'h2);
		bus(1'b1, 6'h0C, 32'h202);
		@(posedge i_clk_sys);
		i_zc_start <= 1'b1; saw_apply <= 1'b0;
		@(posedge i_clk_sys);
		i_zc_start <= 1'b0; i_step_cmd <= 1'b1;
		@(posedge i_clk_sys);
		i_step_cmd <= 1'b0;
		repeat (4) @(negedge i_clk_sys);
		`CHK({saw_apply, o_conversion_ready_out}, 2'h0)
		@(posedge i_clk_sys);
		window(10'h12C);
		repeat (3) @(negedge i_clk_sys);
		`CHK({saw_apply, o_conversion_ready_out}, 2'h3)
		bus(1'b0, 6'h2C, 32'h0);
		`CHK(rd, 32'h12C)
		bus(1'b0, 6'h04, 32'h0);
		`CHK(rd[2:0], 3'h0)
	endtask
	// Supply undervoltage and thermal warning, then clear after recovery
	task automatic t_fault();
		bus(1'b1, 6'h08, 32'h1);
		@(posedge i_clk_sys);
		i_sup_under <= 1'b1; i_temp_warn <= 1'b1;
		repeat (5) @(negedge i_clk_sys);
		`CHK({o_motor_output_enable, o_pump_enable}, 2'h0)
		@(posedge i_clk_sys);
		i_sup_under <= 1'b0; i_temp_warn <= 1'b0;
		bus(1'b1, 6'h08, 32'h1);
		bus(1'b0, 6'h08, 32'h0); `CHK(rd[0], 1'b0)
		bus(1'b0, 6'h00, 32'h0); `CHK({rd[G_TW], rd[G_SUP_UV]}, 2'h3)
		// Phase A never reaches its reference within the short delay
		i_cur_reached_a <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_pwm_start <= 1'b1;
		@(posedge i_clk_sys);
		i_pwm_start <= 1'b0;
		repeat (210) @(posedge i_clk_sys);
		i_cur_reached_a <= 1'b1;
		bus(1'b0, 6'h04, 32'h0);
		`CHK(rd[4:3], 2'h1)
		bus(1'b0, 6'h00, 32'h0);
		`CHK(rd[G_OL], 1'b1)
		bus(1'b1, 6'h00, 32'hFFF);
		bus(1'b0, 6'h00, 32'h0); `CHK(rd[11:0], 12'h000)
		bus(1'b0, 6'h04, 32'h0);
		`CHK(rd[4:3], 2'h0)
		bus(1'b1, 6'h08, 32'h1);
		@(negedge i_clk_sys);
		`CHK({o_motor_output_enable, o_pump_enable, o_fault_summary}, 3'h6)
	endtask
	initial begin
		{h_go, h_wr, h_addr, h_wd, i_pwm_start, i_adc_valid, i_adc_data, i_zc_start} = '0;
		{i_step_cmd, i_result_sel, i_sup_over, i_sup_under, i_reg_over, i_reg_under} = '0;
		{i_reg_por, i_vdd_por, i_pump_low, i_v5_low, i_v5_over, i_v5_below_fail} = '0;
		{i_temp_warn, i_temp_shut, i_overcurrent, saw_apply} = '0;
		{i_cur_reached_a, i_cur_reached_b} = 2'h3;
		mismatches = 0; check_count = 0; cycles = 0;
		i_srst = 1'b1;
		repeat (3) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		@(negedge i_clk_sys);
		t_por();
		t_stall();
		t_delay();
		t_fault();
		close_out();
	end
endmodule

// [cvd_host.sv]
// Host model: Avalon-MM master that reads and clears diagnostic flags on command
`timescale 1ns/100ps
module cvd_host (
	input  wire logic        i_clk_sys,         // System clock
	input  wire logic        i_srst,            // Sync reset, high
	input  wire logic        i_go,              // Start one bus cycle
	input  wire logic        i_wr,              // Write when high
	input  wire logic [5:0]  i_addr,            // Byte address
	input  wire logic [31:0] i_wdata,           // Data to write
	input  wire logic        i_avs_waitrequest, // Slave stall
	input  wire logic [31:0] i_avs_readdata,    // Slave read data
	output logic             o_avs_read,        // Read request
	output logic             o_avs_write,       // Write request
	output logic      [5:0]  o_avs_address,     // Request address
	output logic      [31:0] o_avs_writedata,   // Request data
	output logic             o_done,            // Cycle finished
	output logic      [31:0] o_rdata            // Captured read data
);
	// Quiet bus from time zero
	initial begin
		{o_avs_read, o_avs_write, o_done, o_avs_address, o_avs_writedata, o_rdata} = '0;
	end
	// Request held until waitrequest low; released lines go inverted so stale values never match
	always @(posedge i_clk_sys) begin
		o_done <= 1'b0;
		if (i_srst) begin
			o_avs_read <= 1'b0;
			o_avs_write <= 1'b0;
		end else if ((o_avs_read | o_avs_write) && !i_avs_waitrequest) begin
			o_avs_read <= 1'b0;
			o_avs_write <= 1'b0;
			o_rdata <= i_avs_readdata;
			o_avs_address <= ~o_avs_address;
			o_avs_writedata <= ~o_avs_writedata;
			o_done <= 1'b1;
		end else if (i_go && !(o_avs_read | o_avs_write)) begin
			o_avs_read <= !i_wr;
			o_avs_write <= i_wr;
			o_avs_address <= i_addr;
			o_avs_writedata <= i_wdata;
		end
	end
endmodule

// [cvd_pkg.sv]
// Constants and register map of the coil-voltage stall and fault diagnostic block
package cvd_pkg;
	// Clock and timing
	localparam int CLK_HZ         = 20_000_000;
	localparam int CLK_MHZ        = CLK_HZ / 1_000_000;
	localparam int V5_START_MS    = 4;
	localparam int V5_START_CYC   = V5_START_MS * (CLK_HZ / 1000);
	localparam int OC_FILTER_NS   = 3000;
	localparam int OC_FILTER_CYC  = (OC_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int OL_SHORT_NS    = 10000;
	localparam int OL_LONG_NS     = 40000;
	localparam logic [11:0] OL_SHORT_CYC = 12'((OL_SHORT_NS * CLK_MHZ) / 1000);
	localparam logic [11:0] OL_LONG_CYC  = 12'((OL_LONG_NS * CLK_MHZ) / 1000);
	localparam logic [7:0]  OC_LIMIT     = 8'(OC_FILTER_CYC);
	// Averaging
	localparam int CV_W = 10;
	localparam logic [4:0] SAMP_HI = 5'h10;     // Slow PWM rates
	localparam logic [4:0] SAMP_LO = 5'h08;     // Fast PWM rates
	localparam int SHIFT_HI = 4;
	localparam int SHIFT_LO = 3;
	// Avalon word addresses (byte address bits [5:2])
	localparam logic [3:0] A_GLOBAL_STATUS = 4'h0;
	localparam logic [3:0] A_MOTOR_STATUS  = 4'h1;
	localparam logic [3:0] A_MOTOR_CTRL1   = 4'h2;
	localparam logic [3:0] A_MOTOR_CTRL3   = 4'h3;
	localparam logic [3:0] A_UPPER_LIMIT   = 4'h4;
	localparam logic [3:0] A_LOWER_A       = 4'h5;
	localparam logic [3:0] A_LOWER_B       = 4'h6;
	localparam logic [3:0] A_MOTOR_CTRL2   = 4'h7;
	localparam logic [3:0] A_RESULT0       = 4'h8;   // Results at 0x8..0xB
	// Global status bit positions
	localparam int G_SUP_OV = 0;
	localparam int G_SUP_UV = 1;
	localparam int G_REG_OV = 2;
	localparam int G_REG_UV = 3;
	localparam int G_CP     = 4;
	localparam int G_V5W    = 5;
	localparam int G_V5F    = 6;
	localparam int G_TW     = 7;
	localparam int G_TSD    = 8;
	localparam int G_OC     = 9;
	localparam int G_OL     = 10;
	localparam int G_STALL  = 11;
	localparam int G_W      = 12;
	// Flags that force the motor enable low
	localparam logic [G_W-1:0] ME_BLOCK = 12'h313;
	// Synchronised pin indices
	localparam int P_SUP_OV = 0;
	localparam int P_SUP_UV = 1;
	localparam int P_REG_OV = 2;
	localparam int P_REG_UV = 3;
	localparam int P_REG_POR = 4;
	localparam int P_VDD_POR = 5;
	localparam int P_CP_LOW = 6;
	localparam int P_V5_LOW = 7;
	localparam int P_V5_OV  = 8;
	localparam int P_V5_FAIL = 9;
	localparam int P_TW     = 10;
	localparam int P_TSD    = 11;
	localparam int P_OC     = 12;
	localparam int P_CUR_A  = 13;
	localparam int P_CUR_B  = 14;
	localparam int P_W      = 15;
endpackage
